//--- rtl/slem_pkg.sv
// Purpose: Shared constants and types of the second-level event manager
// Assumes: 32-bit APB register bus, 125 MHz pclk
// Notes: Peripheral slots: 0 timer1, 1 timer2, 2 serial1, 3 serial2, 4 converter
package slem_pkg;

  // ****************************************
  // Sizes and timing
  // ****************************************
  localparam int NPER = 5;
  localparam int NTOP = 17;
  localparam int WD_W = 28;
  localparam real CLK_HZ = 125000000.0;
  localparam real WDOG_LOW_WATER_S = 1.792;
  localparam int unsigned WDOG_LOW_WATER_CYC = int'(WDOG_LOW_WATER_S * CLK_HZ);

  // ****************************************
  // Register byte addresses
  // ****************************************
  localparam logic [11:0] OFS_FLAG0 = 12'h000;
  localparam logic [11:0] OFS_NMI_FLAGS = 12'h014;
  localparam logic [11:0] OFS_MISS = 12'h018;
  localparam logic [11:0] OFS_CFG0 = 12'h040;
  localparam logic [11:0] OFS_TOP_EN_SET = 12'h100;
  localparam logic [11:0] OFS_TOP_EN_CLR = 12'h180;
  localparam logic [11:0] OFS_TOP_PEND_SET = 12'h200;
  localparam logic [11:0] OFS_TOP_PEND_CLR = 12'h280;
  localparam logic [11:0] OFS_AUX_FAULT = 12'h300;
  localparam logic [11:0] OFS_CTRL = 12'h304;
  localparam logic [11:0] OFS_WDOG_RESTART = 12'h308;

  // ****************************************
  // Field layouts
  // ****************************************
  localparam logic [4:0][15:0] PER_MASK = {16'h001F, 16'h1FFF, 16'h7FFF, 16'h005F, 16'h005F};
  localparam logic [4:0][4:0] PER_TOP = {5'h0B, 5'h06, 5'h05, 5'h01, 5'h00};
  localparam logic [16:0] DIRECT_MASK = 17'h1F79C;
  localparam int NMI_XTAL = 0;
  localparam int NMI_WDOG = 1;
  localparam int AF_MISSED = 0;
  localparam int AF_RESERVED = 1;
  localparam int AF_PROTECTED = 2;
  localparam int AF_WRONG_SIZE = 3;
  localparam int CTRL_XTAL = 0;
  localparam int CTRL_WDOG = 1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic valid;
    logic write;
    logic unpriv;
    logic [1:0] size;
    logic [1:0] addr_lo;
    logic is_apb_reg;
    logic is_sys_periph;
    logic is_prot_ram;
    logic beyond_last_reg;
    logic beyond_mem_top;
  } slem_access_t;

  typedef struct packed {
    logic [NPER-1:0][15:0] flags;
    logic [NPER-1:0][15:0] cfg;
    logic [NTOP-1:0] miss;
    logic [NTOP-1:0] top_en;
    logic [NTOP-1:0] top_pend;
    logic [NTOP-1:0] irq;
    logic [1:0] nmi_flags;
    logic nmi;
    logic [3:0] afsr;
    logic hard_fault;
    logic bus_fault;
    logic on_xtal;
    logic xfail_pend;
    logic wdog_en;
    logic [WD_W-1:0] wdog_cnt;
    logic [2:0] xsync;
    logic xtal_ok;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } slem_state_t;

endpackage : slem_pkg

//--- rtl/slem_top.sv
// Purpose: Second-level event manager with NMI sources and bus fault recording
// Assumes: Event inputs are one-cycle pulses from pclk logic; xtal_ok is an async pin
// Notes: APB slave, two-cycle access phase; all outputs registered
//
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/10ps
module slem_top #(
  parameter int unsigned WDOG_CYCLES = slem_pkg::WDOG_LOW_WATER_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [slem_pkg::NPER-1:0][15:0] periph_event,
  input wire logic [slem_pkg::NTOP-1:0] direct_req,
  input wire logic xtal_ok,
  input wire slem_pkg::slem_access_t sys_access,
  output logic [slem_pkg::NTOP-1:0] top_irq,
  output logic nmi,
  output logic hard_fault,
  output logic bus_fault,
  output logic sysclk_on_xtal
);

  localparam logic [slem_pkg::WD_W-1:0] WD_LAST = slem_pkg::WD_W'(WDOG_CYCLES - 1);

  // ****************************************
  // Address decode
  // ****************************************
  function automatic logic addr_mapped(input logic [11:0] a);
    if (a >= slem_pkg::OFS_FLAG0 && a <= slem_pkg::OFS_MISS && a[1:0] == 2'h0) begin
      return 1'b1;
    end else if (a >= slem_pkg::OFS_CFG0 && a < slem_pkg::OFS_CFG0 + 12'h014 && a[1:0] == 2'h0) begin
      return 1'b1;
    end else if (a == slem_pkg::OFS_TOP_EN_SET || a == slem_pkg::OFS_TOP_EN_CLR) begin
      return 1'b1;
    end else if (a == slem_pkg::OFS_TOP_PEND_SET || a == slem_pkg::OFS_TOP_PEND_CLR) begin
      return 1'b1;
    end else if (a == slem_pkg::OFS_AUX_FAULT || a == slem_pkg::OFS_CTRL) begin
      return 1'b1;
    end else begin
      return a == slem_pkg::OFS_WDOG_RESTART;
    end
  endfunction : addr_mapped

  slem_pkg::slem_state_t r;
  slem_pkg::slem_state_t r_nxt;
  logic acc_ok;
  logic wr_go;
  logic [31:0] rd_val;
  localparam int NTOP_W = slem_pkg::NTOP;
  logic [NTOP_W-1:0] per_level;
  logic [3:0] cause;
  logic xtal_lost;

  assign acc_ok = addr_mapped(paddr) && (!pwrite || pstrb == 4'hF);
  assign wr_go = psel && penable && r.pready && pwrite && acc_ok;
  assign xtal_lost = (r.xsync[1] == r.xsync[2]) && !r.xsync[2];

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    r_nxt = r;
    per_level = '0;
    cause = '0;
    rd_val = slem_pkg::RESET_WORD;
    // Event capture, masking and miss detection
    for (int p = 0; p < slem_pkg::NPER; p++) begin
      if (|(r.flags[p] & r.cfg[p])) begin
        per_level[slem_pkg::PER_TOP[p]] = 1'b1;
      end
      if (|(periph_event[p] & r.cfg[p] & r.flags[p] & slem_pkg::PER_MASK[p])) begin
        r_nxt.miss[slem_pkg::PER_TOP[p]] = 1'b1;
      end
      if (wr_go && paddr == slem_pkg::OFS_FLAG0 + 12'(4 * p)) begin
        r_nxt.flags[p] = r.flags[p] & ~pwdata[15:0];
      end
      if (wr_go && paddr == slem_pkg::OFS_CFG0 + 12'(4 * p)) begin
        r_nxt.cfg[p] = pwdata[15:0] & slem_pkg::PER_MASK[p];
      end
      r_nxt.flags[p] = r_nxt.flags[p] | (periph_event[p] & slem_pkg::PER_MASK[p]);
    end
    // Top-level enable and pending latches
    if (wr_go && paddr == slem_pkg::OFS_TOP_EN_SET) begin
      r_nxt.top_en = r.top_en | pwdata[16:0];
    end
    if (wr_go && paddr == slem_pkg::OFS_TOP_EN_CLR) begin
      r_nxt.top_en = r.top_en & ~pwdata[16:0];
    end
    if (wr_go && paddr == slem_pkg::OFS_TOP_PEND_CLR) begin
      r_nxt.top_pend = r.top_pend & ~pwdata[16:0];
    end
    if (wr_go && paddr == slem_pkg::OFS_TOP_PEND_SET) begin
      r_nxt.top_pend = r.top_pend | pwdata[16:0];
    end
    // Level sources hold pending against any clear
    r_nxt.top_pend = r_nxt.top_pend | per_level | (direct_req & slem_pkg::DIRECT_MASK);
    r_nxt.irq = r.top_pend & r.top_en;
    if (wr_go && paddr == slem_pkg::OFS_MISS) begin
      r_nxt.miss = r_nxt.miss & ~pwdata[16:0];
      for (int p = 0; p < slem_pkg::NPER; p++) begin
        if (|(periph_event[p] & r.cfg[p] & r.flags[p] & slem_pkg::PER_MASK[p])) begin
          r_nxt.miss[slem_pkg::PER_TOP[p]] = 1'b1;
        end
      end
    end
    // Crystal supervision
    // Loss counts only once stages two and three agree
    r_nxt.xsync = {r.xsync[1:0], xtal_ok};
    if (r.xsync[1] == r.xsync[2]) begin
      r_nxt.xtal_ok = r.xsync[2];
    end
    if (wr_go && paddr == slem_pkg::OFS_CTRL) begin
      r_nxt.on_xtal = pwdata[slem_pkg::CTRL_XTAL] && r.xtal_ok;
      r_nxt.wdog_en = pwdata[slem_pkg::CTRL_WDOG];
    end
    r_nxt.xfail_pend = 1'b0;
    if (r.on_xtal && xtal_lost) begin
      r_nxt.on_xtal = 1'b0;
      r_nxt.xfail_pend = 1'b1;
    end
    // Watchdog low-water mark
    // Counter saturates: one low-water event per restart
    if (!r.wdog_en || (wr_go && paddr == slem_pkg::OFS_WDOG_RESTART)) begin
      r_nxt.wdog_cnt = '0;
    end else if (r.wdog_cnt != WD_LAST) begin
      r_nxt.wdog_cnt = r.wdog_cnt + 1'b1;
    end
    if (wr_go && paddr == slem_pkg::OFS_NMI_FLAGS) begin
      r_nxt.nmi_flags = r.nmi_flags & ~pwdata[1:0];
    end
    if (r.xfail_pend) begin
      r_nxt.nmi_flags[slem_pkg::NMI_XTAL] = 1'b1;
    end
    if (r.wdog_en && r.wdog_cnt == WD_LAST - 1'b1) begin
      r_nxt.nmi_flags[slem_pkg::NMI_WDOG] = 1'b1;
    end
    r_nxt.nmi = |r.nmi_flags;
    // Bus fault causes
    if (sys_access.valid) begin
      cause[slem_pkg::AF_WRONG_SIZE] = (sys_access.is_apb_reg && sys_access.size != slem_pkg::SIZE_WORD)
        || (sys_access.size == slem_pkg::SIZE_WORD && sys_access.addr_lo != 2'h0);
      cause[slem_pkg::AF_PROTECTED] = sys_access.write && sys_access.unpriv
        && (sys_access.is_sys_periph || sys_access.is_prot_ram);
      cause[slem_pkg::AF_RESERVED] = sys_access.beyond_last_reg || sys_access.beyond_mem_top;
    end
    if (wr_go && paddr == slem_pkg::OFS_AUX_FAULT) begin
      r_nxt.afsr = r.afsr & ~pwdata[3:0];
    end
    r_nxt.afsr = r_nxt.afsr | cause;
    r_nxt.hard_fault = 1'b0;
    r_nxt.bus_fault = 1'b0;
    if (cause != 4'h0) begin
      if (r.afsr != 4'h0) begin
        r_nxt.afsr[slem_pkg::AF_MISSED] = 1'b1;
        r_nxt.hard_fault = 1'b1;
      end else begin
        r_nxt.bus_fault = 1'b1;
      end
    end
    // Register read mux
    if (paddr >= slem_pkg::OFS_FLAG0 && paddr < slem_pkg::OFS_NMI_FLAGS) begin
      rd_val = {16'h0000, r.flags[paddr[4:2]]};
    end else if (paddr == slem_pkg::OFS_NMI_FLAGS) begin
      rd_val = {30'h0000_0000, r.nmi_flags};
    end else if (paddr == slem_pkg::OFS_MISS) begin
      rd_val = {15'h0000, r.miss};
    end else if (paddr >= slem_pkg::OFS_CFG0 && paddr < slem_pkg::OFS_CFG0 + 12'h014) begin
      rd_val = {16'h0000, r.cfg[paddr[4:2]]};
    end else if (paddr == slem_pkg::OFS_TOP_EN_SET || paddr == slem_pkg::OFS_TOP_EN_CLR) begin
      rd_val = {15'h0000, r.top_en};
    end else if (paddr == slem_pkg::OFS_TOP_PEND_SET || paddr == slem_pkg::OFS_TOP_PEND_CLR) begin
      rd_val = {15'h0000, r.top_pend};
    end else if (paddr == slem_pkg::OFS_AUX_FAULT) begin
      rd_val = {28'h000_0000, r.afsr};
    end else if (paddr == slem_pkg::OFS_CTRL) begin
      rd_val = {30'h0000_0000, r.wdog_en, r.on_xtal};
    end
    // APB handshake: ready one cycle into the access phase
    if (psel && penable && !r.pready) begin
      r_nxt.pready = 1'b1;
      r_nxt.pslverr = !acc_ok;
      r_nxt.prdata = (pwrite || !acc_ok) ? slem_pkg::RESET_WORD : rd_val;
    end else begin
      r_nxt.pready = 1'b0;
      r_nxt.pslverr = 1'b0;
      r_nxt.prdata = slem_pkg::RESET_WORD;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else if (clk_en) begin
      r <= r_nxt;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign top_irq = r.irq;
  assign nmi = r.nmi;
  assign hard_fault = r.hard_fault;
  assign bus_fault = r.bus_fault;
  assign sysclk_on_xtal = r.on_xtal;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !clk_en);

  logic clr_t1;
  assign clr_t1 = wr_go && paddr == slem_pkg::OFS_FLAG0 && pwdata[0];

  property p_flag_set;
    periph_event[0][0] |=> r.flags[0][0];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("event did not set flag");

  property p_clear_race;
    clr_t1 && periph_event[0][0] |=> r.flags[0][0];
  endproperty
  a_clear_race: assert property (p_clear_race) else $error("event lost during clear");

  property p_w1c;
    clr_t1 && !periph_event[0][0] |=> !r.flags[0][0];
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag not cleared by write 1");

  sequence s_enabled_flag;
    r.flags[2][0] && r.cfg[2][0];
  endsequence
  property p_propagate;
    s_enabled_flag ##1 r.top_en[5] |=> top_irq[5];
  endproperty
  a_propagate: assert property (p_propagate) else $error("enabled flag not at top level");

  property p_level_hold;
    s_enabled_flag |=> r.top_pend[5];
  endproperty
  a_level_hold: assert property (p_level_hold) else $error("pending dropped under level");

  property p_miss;
    periph_event[4][0] && r.cfg[4][0] && r.flags[4][0] |=> r.miss[11];
  endproperty
  a_miss: assert property (p_miss) else $error("miss not recorded");

  sequence s_xtal_fail;
    r.on_xtal && xtal_lost;
  endsequence
  property p_xtal;
    s_xtal_fail |=> !sysclk_on_xtal ##1 r.nmi_flags[0] ##1 nmi;
  endproperty
  a_xtal: assert property (p_xtal) else $error("crystal failure sequence wrong");

  property p_nmi_src;
    nmi |-> $past(r.nmi_flags) != 2'h0;
  endproperty
  a_nmi_src: assert property (p_nmi_src) else $error("nmi without source");

  property p_wdog;
    r.wdog_en && r.wdog_cnt == WD_LAST - 1'b1 |=> r.nmi_flags[1] ##1 nmi;
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog did not raise nmi");

  property p_second_fault;
    sys_access.valid && sys_access.write && sys_access.unpriv && sys_access.is_sys_periph && r.afsr != 4'h0
      |=> hard_fault && r.afsr[0] && !bus_fault;
  endproperty
  a_second_fault: assert property (p_second_fault) else $error("second fault not escalated");

  property p_first_fault;
    sys_access.valid && sys_access.beyond_last_reg && r.afsr == 4'h0 |=> bus_fault && !hard_fault;
  endproperty
  a_first_fault: assert property (p_first_fault) else $error("first fault not a bus fault");

  property p_wrong_size;
    sys_access.valid && sys_access.is_apb_reg && sys_access.size != slem_pkg::SIZE_WORD
      |=> r.afsr[slem_pkg::AF_WRONG_SIZE];
  endproperty
  a_wrong_size: assert property (p_wrong_size) else $error("wrong size not recorded");

  property p_protected;
    sys_access.valid && sys_access.write && sys_access.unpriv && sys_access.is_sys_periph
      |=> r.afsr[slem_pkg::AF_PROTECTED];
  endproperty
  a_protected: assert property (p_protected) else $error("protection fault not recorded");

  property p_reserved;
    sys_access.valid && sys_access.beyond_last_reg |=> r.afsr[slem_pkg::AF_RESERVED];
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved fault not recorded");

  property p_cfg_write;
    wr_go && paddr == slem_pkg::OFS_CFG0 |=> r.cfg[0][0] == $past(pwdata[0]);
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("enable bit not written");

  property p_miss_w1c;
    wr_go && paddr == slem_pkg::OFS_MISS && pwdata[0] && !periph_event[0][0] |=> !r.miss[0];
  endproperty
  a_miss_w1c: assert property (p_miss_w1c) else $error("miss bit not cleared");

  property p_irq_mask;
    !r.top_en[7] |=> !top_irq[7];
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked request reached top level");

  property p_pend_clr;
    wr_go && paddr == slem_pkg::OFS_TOP_PEND_CLR && pwdata[7] && !direct_req[7] |=> !r.top_pend[7];
  endproperty
  a_pend_clr: assert property (p_pend_clr) else $error("pending bit not cleared");

endmodule : slem_top

//--- bench/slem_event_model.sv
// Purpose: Peripheral event sources and crystal pin beside the event manager
// Assumes: Everything changes just after a pclk rising edge
// Notes: Event bits are held for a chosen number of cycles
`timescale 1ns/10ps
module slem_event_model (
  input wire logic pclk,
  output logic [slem_pkg::NPER-1:0][15:0] periph_event,
  output logic xtal_ok
);
  initial begin
    periph_event = '0;
    xtal_ok = 1'b1;
  end

  // Raise event bits of one slot for n cycles
  task automatic fire(input int slot, input logic [15:0] bits, input int n);
    @(posedge pclk);
    periph_event[slot] <= bits;
    repeat (n) @(posedge pclk);
    periph_event[slot] <= 16'h0000;
  endtask : fire

  // Crystal running or failed
  task automatic set_xtal(input logic v);
    @(posedge pclk);
    xtal_ok <= v;
  endtask : set_xtal
endmodule : slem_event_model

//--- bench/tb_slem_top.sv
// Purpose: Self-checking bench of the second-level event manager
// Assumes: APB master tasks, event model, short watchdog count
// Notes: Expected values are worked out from the bit layouts
`timescale 1ns/10ps
module tb_slem_top;
  localparam int WD = 20;
  logic pclk, presetn, clk_en, psel, penable, pwrite;
  logic pready, pslverr, nmi, hard_fault, bus_fault, sysclk_on_xtal, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [slem_pkg::NTOP-1:0] direct_req, top_irq;
  logic [slem_pkg::NPER-1:0][15:0] periph_event;
  logic xtal_ok;
  slem_pkg::slem_access_t sys_access;
  logic [15:0] lay [5] = '{16'h005F, 16'h005F, 16'h7FFF, 16'h1FFF, 16'h001F};
  int pos [5] = '{0, 1, 5, 6, 11};
  int num_errors = 0;
  int tests_run = 0;

  always #4 pclk = ~pclk;

  slem_top #(.WDOG_CYCLES(WD)) uut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .periph_event, .direct_req, .xtal_ok, .sys_access, .top_irq, .nmi,
    .hard_fault, .bus_fault, .sysclk_on_xtal);
  slem_event_model em (.pclk, .periph_event, .xtal_ok);

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rc

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : tick

  // One access: byte or word, low address bits, unprivileged write, beyond last register
  task automatic fault(input logic [1:0] s, input logic [1:0] lo, input logic w, input logic b);
    @(posedge pclk);
    sys_access <= '{valid: 1'b1, write: w, unpriv: w, size: s, addr_lo: lo, is_apb_reg: 1'b1,
      is_sys_periph: w, is_prot_ram: 1'b0, beyond_last_reg: b, beyond_mem_top: 1'b0};
    @(posedge pclk);
    sys_access <= '0;
    #1;
  endtask : fault

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    #200000;
    num_errors++;
    report_and_stop();
  end

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    direct_req = '0;
    sys_access = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rc(12'(4 * i), 32'h0);
      rc(12'h040 + 12'(4 * i), 32'h0);
    end
    rc(12'h018, 32'h0);
    rc(12'h3FC, 32'h0);
    chk({31'h0, err}, 32'h1);
    clk_en <= 1'b0;
    em.fire(0, 16'h0001, 1);
    clk_en <= 1'b1;
    rc(12'h000, 32'h0);
    $display("reset and map test done");
    wr(12'h100, 32'h0001_FFFF);
    for (int i = 0; i < 5; i++) begin
      em.fire(i, 16'hFFFF, 1);
      tick(4);
      rc(12'(4 * i), {16'h0, lay[i]});
      chk({15'h0, top_irq}, 32'h0);
      wr(12'(4 * i), 32'h0000_FFFF);
      rc(12'(4 * i), 32'h0);
      rc(12'h018, 32'h0);
      em.fire(i, 16'h0001, 1);
      wr(12'h040 + 12'(4 * i), 32'h3);
      tick(4);
      chk({15'h0, top_irq}, 32'h1 << pos[i]);
      em.fire(i, 16'h0001, 1);
      tick(2);
      rc(12'h018, 32'h1 << pos[i]);
      em.fire(i, 16'h0002, 1);
      wr(12'(4 * i), 32'h0);
      rc(12'(4 * i), 32'h3);
      wr(12'(4 * i), 32'h1);
      wr(12'h280, 32'h1 << pos[i]);
      tick(4);
      chk({15'h0, top_irq}, 32'h1 << pos[i]);
      wr(12'(4 * i), 32'h2);
      wr(12'h280, 32'h1 << pos[i]);
      tick(4);
      chk({15'h0, top_irq}, 32'h0);
      wr(12'h018, 32'h0);
      rc(12'h018, 32'h1 << pos[i]);
      wr(12'h018, 32'h1 << pos[i]);
      rc(12'h018, 32'h0);
      wr(12'h040 + 12'(4 * i), 32'h0);
    end
    $display("flag and mask test done");
    fork
      em.fire(0, 16'h0001, 3);
      wr(12'h000, 32'h1);
    join
    rc(12'h000, 32'h1);
    wr(12'h000, 32'h1);
    pstrb <= 4'h3;
    wr(12'h040, 32'h0000_0001);
    chk({31'h0, err}, 32'h1);
    pstrb <= 4'hF;
    rc(12'h040, 32'h0);
    wr(12'h180, 32'h80);
    wr(12'h200, 32'h80);
    tick(4);
    chk({15'h0, top_irq}, 32'h0);
    rc(12'h200, 32'h80);
    wr(12'h100, 32'h80);
    tick(4);
    chk({15'h0, top_irq}, 32'h80);
    wr(12'h280, 32'h80);
    direct_req <= 17'h4;
    tick(4);
    chk({15'h0, top_irq}, 32'h4);
    @(posedge pclk);
    direct_req <= 17'h0;
    wr(12'h280, 32'h4);
    tick(4);
    chk({15'h0, top_irq}, 32'h0);
    $display("top level test done");
    wr(12'h304, 32'h1);
    tick(4);
    chk({31'h0, sysclk_on_xtal}, 32'h1);
    chk({31'h0, nmi}, 32'h0);
    em.set_xtal(1'b0);
    tick(10);
    chk({31'h0, sysclk_on_xtal}, 32'h0);
    chk({31'h0, nmi}, 32'h1);
    rc(12'h014, 32'h1);
    em.set_xtal(1'b1);
    wr(12'h014, 32'h1);
    tick(3);
    chk({31'h0, nmi}, 32'h0);
    wr(12'h304, 32'h2);
    tick(WD - 8);
    wr(12'h308, 32'h0);
    tick(WD - 5);
    chk({31'h0, nmi}, 32'h0);
    tick(8);
    chk({31'h0, nmi}, 32'h1);
    rc(12'h014, 32'h2);
    wr(12'h304, 32'h0);
    wr(12'h014, 32'h2);
    $display("nmi test done");
    fault(2'h0, 2'h0, 1'b0, 1'b0);
    chk({31'h0, bus_fault}, 32'h1);
    rc(12'h300, 32'h8);
    fault(2'h2, 2'h0, 1'b1, 1'b0);
    chk({31'h0, hard_fault}, 32'h1);
    rc(12'h300, 32'hD);
    wr(12'h300, 32'hF);
    fault(2'h2, 2'h2, 1'b0, 1'b1);
    chk({31'h0, bus_fault}, 32'h1);
    rc(12'h300, 32'hA);
    $display("fault test done");
    report_and_stop();
  end
endmodule : tb_slem_top
